// ---- pkg/smb_host_pkg.sv ----
// package for the smbus host controller of the clock buffer
// assumes a 50 MHz system clock and an open-drain smbus with pullups
package smb_host_pkg;

  // ****************************************
  // device register map
  // ****************************************
  localparam logic [7:0] pll_mode_freq_ctrl_off  = 8'h00;
  localparam logic [7:0] output_enable_low_off   = 8'h01;
  localparam logic [7:0] output_enable_high_off  = 8'h02;
  localparam logic [7:0] reserved_byte_three_off = 8'h03;
  localparam logic [7:0] byte_count_off          = 8'h08;

  localparam int mode_readback_hi_bit   = 7;
  localparam int mode_readback_lo_bit   = 6;
  localparam int loop_sw_override_bit   = 3;
  localparam int mode_select_hi_bit     = 2;
  localparam int mode_select_lo_bit     = 1;
  localparam int freq_select_latched_bit = 0;

  localparam logic [7:0] pll_mode_freq_ctrl_rst = 8'h06;
  localparam logic [7:0] output_enable_low_rst  = 8'hff;
  localparam logic [7:0] output_enable_high_rst = 8'h0f;
  localparam logic [7:0] output_enable_high_mask = 8'h0f;

  // ****************************************
  // bus timing
  // ****************************************
  localparam int clock_mhz     = 50;
  localparam int scl_half_ns   = 5000;
  localparam int scl_half_cyc  = (scl_half_ns * clock_mhz) / 1000;
  localparam int max_bytes     = 16;

  localparam logic       dir_write = 1'b0;
  localparam logic       dir_read  = 1'b1;

  // ****************************************
  // user command and answer
  // ****************************************
  typedef struct packed {
    logic       read;
    logic [6:0] dev_addr;
    logic [7:0] index;
    logic [4:0] count;
  } cmd_t;

  typedef struct packed {
    logic       done;
    logic       nack_err;
    logic [4:0] count_seen;
  } status_t;

endpackage : smb_host_pkg

// ---- src/smb_bit_engine.sv ----
// smbus bit engine: start, stop, restart, one byte with acknowledge
// assumes scl and sda are open-drain; oe high means the pin is pulled low
`timescale 1ns/100ps
`default_nettype none

module smb_bit_engine (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [1:0] op,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_ack,
  input  wire logic       sda_in_sync,
  input  wire logic       scl_in_sync,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rx_byte,
  output logic            rx_ack,
  output logic            scl_oe,
  output logic            sda_oe
);

  // ****************************************
  // operations
  // ****************************************
  localparam logic [1:0] op_start = 2'b00;
  localparam logic [1:0] op_stop  = 2'b01;
  localparam logic [1:0] op_byte  = 2'b10;
  localparam int bit_last = 8;
  localparam int half_w   = $clog2(smb_host_pkg::scl_half_cyc + 1);
  // sda moves mid low phase, clear of both scl edges
  localparam int data_set = smb_host_pkg::scl_half_cyc / 2;

  typedef enum logic [2:0] {idle, st_a, st_b, st_c, by_low, by_high, sp_a, sp_b} phase_t;

  phase_t            phase_reg;
  logic [half_w-1:0] tick_reg;
  logic [3:0]        bit_reg;
  logic [8:0]        shift_reg;
  logic              tick_end;
  logic              scl_wait;

  assign tick_end = (tick_reg == half_w'(smb_host_pkg::scl_half_cyc - 1));
  // scl released but still low: a target stretches, restart the count from zero
  assign scl_wait = !scl_oe && !scl_in_sync;
  assign busy     = (phase_reg != idle);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= '0;
    end else if (phase_reg == idle || tick_end || scl_wait) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + half_w'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= idle;
      bit_reg   <= '0;
      shift_reg <= '0;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
      done      <= 1'b0;
      rx_byte   <= '0;
      rx_ack    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase_reg)
        idle: if (go) begin
          bit_reg   <= '0;
          shift_reg <= {tx_byte, tx_ack};
          case (op)
            op_start: begin
              sda_oe    <= 1'b0;
              phase_reg <= st_a;
            end
            op_stop: begin
              sda_oe    <= 1'b1;
              phase_reg <= sp_a;
            end
            default: begin
              scl_oe    <= 1'b1;
              phase_reg <= by_low;
            end
          endcase
        end
        // release scl with sda high, then pull sda low: also a repeated start
        st_a: if (tick_end) begin
          scl_oe    <= 1'b0;
          phase_reg <= st_b;
        end
        st_b: if (tick_end) begin
          sda_oe    <= 1'b1;
          phase_reg <= st_c;
        end
        st_c: if (tick_end) begin
          scl_oe    <= 1'b1;
          done      <= 1'b1;
          phase_reg <= idle;
        end
        by_low: begin
          if (tick_reg == half_w'(data_set)) begin
            sda_oe <= ~shift_reg[8];
          end
          if (tick_end) begin
            scl_oe    <= 1'b0;
            phase_reg <= by_high;
          end
        end
        by_high: if (tick_end) begin
          scl_oe    <= 1'b1;
          shift_reg <= {shift_reg[7:0], sda_in_sync};
          if (bit_reg == 4'(bit_last)) begin
            rx_byte   <= shift_reg[7:0];
            rx_ack    <= ~sda_in_sync;
            sda_oe    <= 1'b0;
            done      <= 1'b1;
            phase_reg <= idle;
          end else begin
            bit_reg   <= bit_reg + 4'd1;
            phase_reg <= by_low;
          end
        end
        sp_a: if (tick_end) begin
          scl_oe    <= 1'b0;
          phase_reg <= sp_b;
        end
        sp_b: if (tick_end) begin
          sda_oe    <= 1'b0;
          done      <= 1'b1;
          phase_reg <= idle;
        end
        default: phase_reg <= idle;
      endcase
    end
  end

endmodule // smb_bit_engine

`default_nettype wire

// ---- src/smb_index_host.sv ----
// smbus host for indexed block write and read of the clock buffer
// assumes user command port on the same clock; bus pins are asynchronous
// How it works
// - start, address with write bit, expect ack
// - send index byte, expect ack
// - block write sends count byte, expect ack
// - send count data bytes, each acked
// - host ends block write with stop
// - read: restart, address with read bit
// - host acks every read byte except last
// - host nacks last byte; device releases
// - host ends block read with stop
// - mode change needs warm system reset
`timescale 1ns/100ps
`default_nettype none

module smb_index_host (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire smb_host_pkg::cmd_t   cmd,
  input  wire logic                 cmd_valid,
  input  wire logic                 wr_valid,
  input  wire logic [7:0]           wr_data,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      cmd_ready,
  output logic                      wr_taken,
  output logic                      rd_valid,
  output logic [7:0]                rd_data,
  output smb_host_pkg::status_t     status,
  output logic                      warm_reset_req,
  output logic                      scl_out,
  output logic                      scl_oe,
  output logic                      sda_out,
  output logic                      sda_oe
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] sda_sync_reg;
  logic [1:0] scl_sync_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_sync_reg <= 2'b11;
      scl_sync_reg <= 2'b11;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
    end
  end

  // ****************************************
  // bit engine
  // ****************************************
  localparam logic [1:0] op_start = 2'b00;
  localparam logic [1:0] op_stop  = 2'b01;
  localparam logic [1:0] op_byte  = 2'b10;

  logic       eng_go;
  logic [1:0] eng_op;
  logic [7:0] eng_tx;
  logic       eng_tx_ack;
  logic       eng_busy;
  logic       eng_done;
  logic [7:0] eng_rx;
  logic       eng_rx_ack;
  logic       eng_scl_oe;
  logic       eng_sda_oe;

  smb_bit_engine bits (
    .clock       (clock),
    .rst_n       (rst_n),
    .go          (eng_go),
    .op          (eng_op),
    .tx_byte     (eng_tx),
    .tx_ack      (eng_tx_ack),
    .sda_in_sync (sda_sync_reg[1]),
    .scl_in_sync (scl_sync_reg[1]),
    .busy        (eng_busy),
    .done        (eng_done),
    .rx_byte     (eng_rx),
    .rx_ack      (eng_rx_ack),
    .scl_oe      (eng_scl_oe),
    .sda_oe      (eng_sda_oe)
  );

  // open-drain pins: drive low only
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = eng_scl_oe;
  assign sda_oe  = eng_sda_oe;

  // ****************************************
  // transaction sequencer
  // ****************************************
  typedef enum logic [3:0] {
    s_idle, s_start, s_addr_w, s_index, s_count, s_wdata,
    s_restart, s_addr_r, s_rcount, s_rdata, s_stop, s_finish
  } seq_t;

  seq_t                  seq_reg;
  smb_host_pkg::cmd_t    cmd_reg;
  logic [4:0]            left_reg;
  logic                  err_reg;
  logic                  issued_reg;
  logic                  mode_touch_reg;

  function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic dir);
    addr_byte = {a, dir};
  endfunction

  // engine commands are issued once per operation (once per byte in s_wdata and s_rdata), result taken on done
  always_comb begin
    eng_go     = 1'b0;
    eng_op     = op_byte;
    eng_tx     = 8'h00;
    eng_tx_ack = 1'b1;
    if (!issued_reg && !eng_busy) begin
      case (seq_reg)
        s_start, s_restart: begin
          eng_go = 1'b1;
          eng_op = op_start;
        end
        s_addr_w: begin
          eng_go = 1'b1;
          eng_tx = addr_byte(cmd_reg.dev_addr, smb_host_pkg::dir_write);
        end
        s_index: begin
          eng_go = 1'b1;
          eng_tx = cmd_reg.index;
        end
        s_count: begin
          eng_go = 1'b1;
          eng_tx = {3'b000, cmd_reg.count};
        end
        s_wdata: begin
          eng_go = wr_valid;
          eng_tx = wr_data;
        end
        s_addr_r: begin
          eng_go = 1'b1;
          eng_tx = addr_byte(cmd_reg.dev_addr, smb_host_pkg::dir_read);
        end
        s_rcount: begin
          eng_go     = 1'b1;
          eng_tx     = 8'hff;
          eng_tx_ack = 1'b0;
        end
        s_rdata: begin
          eng_go     = 1'b1;
          eng_tx     = 8'hff;
          eng_tx_ack = (left_reg == 5'd1);
        end
        s_stop: begin
          eng_go = 1'b1;
          eng_op = op_stop;
        end
        default: eng_go = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      issued_reg <= 1'b0;
    end else if (eng_done) begin
      issued_reg <= 1'b0;
    end else if (eng_go) begin
      issued_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg   <= s_idle;
      cmd_reg   <= '0;
      left_reg  <= '0;
      err_reg   <= 1'b0;
      cmd_ready <= 1'b1;
      wr_taken  <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
      status    <= '0;
    end else begin
      wr_taken    <= 1'b0;
      rd_valid    <= 1'b0;
      status.done <= 1'b0;
      case (seq_reg)
        s_idle: if (cmd_valid) begin
          cmd_reg   <= cmd;
          left_reg  <= cmd.count;
          err_reg   <= 1'b0;
          cmd_ready <= 1'b0;
          seq_reg   <= s_start;
        end
        s_start: if (eng_done) seq_reg <= s_addr_w;
        s_addr_w: if (eng_done) begin
          seq_reg <= eng_rx_ack ? s_index : s_stop;
          err_reg <= ~eng_rx_ack;
        end
        s_index: if (eng_done) begin
          if (!eng_rx_ack) begin
            err_reg <= 1'b1;
            seq_reg <= s_stop;
          end else begin
            seq_reg <= cmd_reg.read ? s_restart : s_count;
          end
        end
        s_count: if (eng_done) begin
          err_reg <= ~eng_rx_ack;
          seq_reg <= (eng_rx_ack && left_reg != '0) ? s_wdata : s_stop;
        end
        s_wdata: begin
          if (eng_go) wr_taken <= 1'b1;
          if (eng_done) begin
            left_reg <= left_reg - 5'd1;
            if (!eng_rx_ack) begin
              err_reg <= 1'b1;
              seq_reg <= s_stop;
            end else if (left_reg == 5'd1) begin
              seq_reg <= s_stop;
            end
          end
        end
        s_restart: if (eng_done) seq_reg <= s_addr_r;
        s_addr_r: if (eng_done) begin
          err_reg <= ~eng_rx_ack;
          seq_reg <= eng_rx_ack ? s_rcount : s_stop;
        end
        s_rcount: if (eng_done) begin
          // count set by register eight; clipped to the host's limit
          left_reg <= (eng_rx[7:0] > 8'(smb_host_pkg::max_bytes)) ?
                      5'(smb_host_pkg::max_bytes) : eng_rx[4:0];
          status.count_seen <= eng_rx[4:0];
          seq_reg <= (eng_rx == 8'h00) ? s_stop : s_rdata;
        end
        s_rdata: if (eng_done) begin
          rd_valid <= 1'b1;
          rd_data  <= eng_rx;
          left_reg <= left_reg - 5'd1;
          if (left_reg == 5'd1) seq_reg <= s_stop;
        end
        s_stop: if (eng_done) seq_reg <= s_finish;
        s_finish: begin
          status.done     <= 1'b1;
          status.nack_err <= err_reg;
          cmd_ready       <= 1'b1;
          seq_reg         <= s_idle;
        end
        default: seq_reg <= s_idle;
      endcase
    end
  end

  // ****************************************
  // warm reset request after mode change
  // ****************************************
  // a finished write starting at byte 0 may alter bits 3..1
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_touch_reg <= 1'b0;
      warm_reset_req <= 1'b0;
    end else begin
      warm_reset_req <= 1'b0;
      if (seq_reg == s_idle && cmd_valid && !cmd.read &&
          cmd.index == smb_host_pkg::pll_mode_freq_ctrl_off && cmd.count != '0) begin
        mode_touch_reg <= 1'b1;
      end else if (seq_reg == s_finish) begin
        warm_reset_req <= mode_touch_reg & ~err_reg;
        mode_touch_reg <= 1'b0;
      end
    end
  end

endmodule // smb_index_host

`default_nettype wire

// ---- sim/smb_dev_model.sv ----
// behavioural smbus target with the clock buffer control bytes
// assumes pulled-up open-drain scl and sda resolved by the bench
`timescale 1ns/100ps
`default_nettype none

module smb_dev_model #(
  parameter logic [6:0] dev_addr  = 7'h69, // arbitrary value
  parameter logic [1:0] mode_pin  = 2'b01,
  parameter logic       freq_pin  = 1'b1,
  parameter logic [7:0] count_rst = 8'h04
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       warm_rst,
  output var  logic       sda_oe,
  output var  logic [1:0] pll_mode
);
  // **********
  // registers and bus service
  // **********
  logic [2:0] sw    = smb_host_pkg::pll_mode_freq_ctrl_rst[3:1];
  logic [7:0] oe_lo = smb_host_pkg::output_enable_low_rst;
  logic [3:0] oe_hi = smb_host_pkg::output_enable_high_rst[3:0];
  logic [7:0] cnt   = count_rst;
  logic [7:0] ptr, b, n;
  int         ev;
  logic       nk;
  // output 4 has its enable pin deasserted
  localparam logic [11:0] out_oe_n = 12'h010;
  wire logic [11:0] out_run;
  assign out_run = {oe_hi, oe_lo} & ~out_oe_n;

  function automatic logic [7:0] rd(input logic [7:0] p);
    case (p)
      8'h00: return {mode_pin, 2'b00, sw, freq_pin};
      8'h01: return oe_lo;
      8'h02: return {4'h0, oe_hi};
      8'h08: return cnt;
      default: return 8'h00;
    endcase
  endfunction

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    case (p)
      8'h00: sw = d[3:1];
      8'h01: oe_lo = d;
      8'h02: oe_hi = d[3:0];
      8'h08: cnt = d;
      default: ;
    endcase
  endtask

  initial pll_mode = mode_pin;
  always @(posedge warm_rst) pll_mode = sw[2] ? sw[1:0] : mode_pin;

  // e: 0 byte, 1 repeated start, 2 stop
  task automatic rx(output logic [7:0] v, output int e);
    e = 0;
    v = 8'h00;
    for (int i = 7; i >= 0 && e == 0; i--) begin
      @(posedge scl);
      v[i] = sda;
      @(negedge scl or sda);
      if (scl) e = sda ? 2 : 1;
    end
  endtask

  task automatic ack;
    sda_oe = 1'b1;
    @(negedge scl);
    sda_oe = 1'b0;
  endtask

  task automatic tx(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      sda_oe = ~v[i];
      @(negedge scl);
    end
    sda_oe = 1'b0;
    @(posedge scl);
    nk = sda;
    @(negedge scl);
  endtask

  initial begin
    sda_oe = 1'b0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      rx(b, ev);
      if (ev == 0 && b == {dev_addr, 1'b0}) begin
        ack();
        rx(ptr, ev);
        ack();
        rx(n, ev);
        if (ev == 1) begin
          rx(b, ev);
          if (b == {dev_addr, 1'b1}) begin
            ack();
            tx(cnt);
            for (int i = 0; i < cnt && !nk; i++) begin
              tx(rd(ptr));
              ptr++;
            end
          end
        end else if (ev == 0) begin
          ack();
          for (int i = 0; i < n && ev == 0; i++) begin
            rx(b, ev);
            if (ev == 0) ack();
            if (ev == 0) wr(ptr, b);
            ptr++;
          end
        end
      end
    end
  end
endmodule // smb_dev_model
`default_nettype wire

// ---- sim/smb_index_host_chk.sv ----
// assertions on the smbus host controller ports
// assumes one clock domain with async active-low reset
`timescale 1ns/100ps
`default_nettype none

module smb_index_host_chk (
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic                  cmd_valid,
  input wire logic                  cmd_ready,
  input wire logic                  wr_taken,
  input wire logic                  rd_valid,
  input wire smb_host_pkg::status_t status,
  input wire logic                  warm_reset_req,
  input wire logic                  scl_oe,
  input wire logic                  sda_oe
);
  // **********
  // port relations
  // **********
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_TAKE: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("command not taken");
  AST_START_BUSY: assert property ($rose(sda_oe) && !scl_oe |-> !cmd_ready)
    else $error("start while idle");
  AST_IDLE_FREE: assert property (cmd_ready |-> !scl_oe && !sda_oe)
    else $error("bus held while idle");
  AST_DONE_READY: assert property (status.done |-> ##[0:1] cmd_ready)
    else $error("not idle after done");
  AST_DONE_PULSE: assert property (status.done |=> !status.done)
    else $error("done longer than a cycle");
  AST_WR_BYTE: assert property (wr_taken |-> !cmd_ready ##1 !wr_taken)
    else $error("bad write byte take");
  AST_RD_BYTE: assert property (rd_valid |-> !cmd_ready ##1 !rd_valid)
    else $error("bad read byte strobe");
  AST_SCL_HOLD: assert property ($changed(scl_oe) |=> $stable(scl_oe) [*8])
    else $error("scl half period too short");
  AST_WARM_OK: assert property (warm_reset_req |-> !status.nack_err)
    else $error("warm reset after failed write");

  cover property (status.done && !status.nack_err);
  cover property (rd_valid);
  cover property ($rose(status.nack_err));
endmodule // smb_index_host_chk

bind smb_index_host smb_index_host_chk smb_index_host_chk_inst (
  .clock, .rst_n, .cmd_valid, .cmd_ready, .wr_taken, .rd_valid, .status,
  .warm_reset_req, .scl_oe, .sda_oe
);
`default_nettype wire

// ---- sim/smb_index_host_tb.sv ----
// self-checking bench for the smbus host with a device model
// assumes the model pulls sda only and never stretches scl
`timescale 1ns/100ps
`default_nettype none

module smb_index_host_tb;
  // **********
  // bench
  // **********
  localparam logic [6:0] addr = 7'h69;
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b0;
  smb_host_pkg::cmd_t    cmd = '0;
  logic                  cmd_valid = 1'b0;
  logic                  wr_valid = 1'b0;
  logic [7:0]            wr_data = 8'h00;
  smb_host_pkg::status_t status, last;
  logic [7:0]            rd_data, wrq[$], rdq[$];
  logic [1:0]            pll_mode;
  logic                  cmd_ready, wr_taken, rd_valid, warm_reset_req, scl_oe, sda_oe, dev_oe;
  logic                  done_seen = 1'b0;
  int                    miscompares = 0, checks_done = 0, taken = 0, warms = 0, cycles = 0;
  logic                  scl_out, sda_out;
  wire                   scl = scl_oe ? scl_out : 1'b1;
  wire                   sda = (sda_oe ? sda_out : 1'b1) & ~dev_oe;

  always #10 clock = ~clock;

  smb_index_host smb_index_host_inst (
    .clock, .rst_n, .cmd, .cmd_valid, .wr_valid, .wr_data, .scl_in(scl), .sda_in(sda),
    .cmd_ready, .wr_taken, .rd_valid, .rd_data, .status, .warm_reset_req,
    .scl_out, .scl_oe, .sda_out, .sda_oe
  );
  smb_dev_model #(.dev_addr(addr)) smb_dev_model_inst (
    .scl, .sda, .warm_rst(warm_reset_req), .sda_oe(dev_oe), .pll_mode
  );

  always @(posedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      print_verdict();
    end
  end

  always @(negedge clock) begin
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (warm_reset_req === 1'b1) warms++;
    if (status.done === 1'b1) begin
      done_seen = 1'b1;
      last = status;
    end
    if (wr_taken === 1'b1) begin
      void'(wrq.pop_front());
      taken++;
    end
    wr_valid = wrq.size() > 0;
    wr_data = wrq.size() > 0 ? wrq[0] : 8'h00;
  end

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic run(input logic rd, input logic [6:0] a, input logic [7:0] idx,
                     input logic [4:0] n);
    int t;
    t = 0;
    done_seen = 1'b0;
    cmd = '{rd, a, idx, n};
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    while (done_seen !== 1'b1 && t < 40000) begin
      @(negedge clock);
      t++;
    end
    cmp("done", 8'h01, {7'h00, done_seen});
  endtask

  task automatic s_write;
    cmp("reg0 reset", 8'h47, smb_dev_model_inst.rd(8'h00));
    cmp("reg1 reset", 8'hff, smb_dev_model_inst.rd(8'h01));
    cmp("reg2 reset", 8'h0f, smb_dev_model_inst.rd(8'h02));
    wrq = '{8'hff, 8'h5a, 8'hf3, 8'hff};
    run(1'b0, addr, smb_host_pkg::pll_mode_freq_ctrl_off, 5'd4);
    cmp("write nack", 8'h00, {7'h00, last.nack_err});
    cmp("bytes taken", 8'h04, 8'(taken));
    cmp("warm resets", 8'h01, 8'(warms));
    cmp("reg0", 8'h4f, smb_dev_model_inst.rd(8'h00));
    cmp("reg1", 8'h5a, smb_dev_model_inst.rd(8'h01));
    cmp("reg2", 8'h03, smb_dev_model_inst.rd(8'h02));
    cmp("pll mode", 8'h03, {6'h00, pll_mode});
    cmp("outputs low", 8'h4a, smb_dev_model_inst.out_run[7:0]);
    cmp("outputs high", 8'h03, {4'h0, smb_dev_model_inst.out_run[11:8]});
  endtask

  task automatic s_read;
    logic [7:0] exp[4] = '{8'h5a, 8'h03, 8'h00, 8'h00};
    run(1'b1, addr, smb_host_pkg::output_enable_low_off, 5'd4);
    cmp("read nack", 8'h00, {7'h00, last.nack_err});
    cmp("count seen", 8'h04, {3'h0, last.count_seen});
    cmp("bytes read", 8'h04, 8'(rdq.size()));
    foreach (exp[i]) cmp("read byte", exp[i], rdq.size() > i ? rdq[i] : 8'hxx);
  endtask

  task automatic s_nack;
    run(1'b0, addr ^ 7'h01, smb_host_pkg::pll_mode_freq_ctrl_off, 5'd1);
    cmp("addr nack", 8'h01, {7'h00, last.nack_err});
    cmp("no warm", 8'h01, 8'(warms));
  endtask

  initial begin
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    s_write();
    s_read();
    s_nack();
    print_verdict();
  end
endmodule // smb_index_host_tb
`default_nettype wire
